// File: bench/sar_assertions.sv
// Pin checks between the controller and SDRAM ends
`timescale 1ns/1ns
`default_nettype none
module sar_assertions (
   input wire logic ref_clk, // Clock
   input wire logic rstn, // Reset
   input wire logic csN, // Select
   input wire logic rasN, // Row
   input wire logic casN, // Column
   input wire logic weN, // Write
   input wire logic [sar_pkg::BANK_W-1:0] bankSel, // Bank
   input wire logic [sar_pkg::ROW_W-1:0] addr, // Address
   input wire logic [sar_pkg::LANES-1:0] byteMask, // Mask
   input wire logic [sar_pkg::DQ_W-1:0] dqOut, // Data
   input wire logic [sar_pkg::LANES-1:0] dqOe // Enables
);
   import sar_pkg::*;
   // ----------
   // Properties
   // ----------
   wire logic [2:0] op = csN ? 3'h7 : {rasN, casN, weN};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_lane_mask: assert property (dqOe[0] |-> !$past(byteMask[0], 2))
      else $error("lane driven while masked");
   a_first_beat: assert property (dqOe == 2'h3 && $past(dqOe) == 2'h0 &&
      $past(byteMask, 3) == 2'h0 |-> $past(op, 3) == CMD_READ && dqOut[8:0] == $past(addr[8:0], 3))
      else $error("first beat late or wrong");
   a_beat_step: assert property (dqOe == 2'h3 ##1 (dqOe == 2'h3 && $past(op, 3) != CMD_READ)
      |-> dqOut[0] != $past(dqOut[0])) else $error("column did not advance");
   a_write_hiz: assert property (op == CMD_WRITE |=> (dqOe == 2'h0) [*3])
      else $error("data driven after write");
   a_term_stop: assert property (op == CMD_TERMINATE |-> ##3 dqOe == 2'h0)
      else $error("burst ran past terminate");
   a_pre_stop: assert property (op == CMD_PRECHARGE && addr[AP_BIT] |-> ##3 dqOe == 2'h0)
      else $error("burst ran past precharge");
   a_act_gap: assert property (op == CMD_ACTIVE |=> (op != CMD_ACTIVE) [*3])
      else $error("activates too close");
   // Held bank lines stand in for per-bank timers: never misses a case, may misfire on another bank's access
   a_act_read: assert property (op == CMD_ACTIVE |=>
      !(op inside {CMD_READ, CMD_WRITE} && $stable(bankSel)) [*4]) else $error("access too early");
endmodule
`default_nettype wire

// File: bench/tb.sv
// Bench driving the controller over AXI4-Lite and watching the SDRAM pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t bad", $time); end end
module tb;
   import sar_pkg::*;
   logic ref_clk = 0, rstn = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0;
   logic awRdy, wRdy, bVld, arRdy, rVld, inv;
   logic [1:0] rresp, bresp, bk, lm;
   logic [2:0] code = 3'h0;
   logic [3:0] act;
   logic [7:0] addr = 8'h00;
   logic [8:0] c, m;
   logic [11:0] rw;
   logic [31:0] data = 32'h0, rdata;
   logic [17:0] q[$];
   int err_count = 0, n_compared = 0, cyc = 0, seen, t, k, i;
   sar_if bus ();
   sar_ctrl sar_ctrl_i (.ref_clk, .rstn, .mem(bus), .awvalid(aw), .awready(awRdy), .awaddr(addr),
      .wvalid(w), .wready(wRdy), .wdata(data), .wstrb(4'hF), .bvalid(bVld), .bready(b),
      .bresp(bresp), .arvalid(ar), .arready(arRdy), .araddr(addr), .rvalid(rVld), .rready(r),
      .rdata(rdata), .rresp(rresp));
   sar_device sar_device_i (.ref_clk, .rstn, .bus(bus), .burstCode(code), .bankActive(act),
      .invalidWrite(inv));
   sar_assertions sar_assertions_i (.ref_clk, .rstn, .csN(bus.csN), .rasN(bus.rasN),
      .casN(bus.casN), .weN(bus.weN), .bankSel(bus.bankSel), .addr(bus.addr),
      .byteMask(bus.byteMask), .dqOut(bus.dqOut), .dqOe(bus.dqOe));
   // --------------
   // Drivers
   // --------------
   task automatic limit(input int n);
      if (n >= 60) begin
         err_count++;
         $display("FAIL %0t timeout", $time);
         wrap_up();
      end
   endtask
   task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      addr <= a;
      data <= d;
      ar <= rd;
      aw <= !rd;
      w <= !rd;
      b <= 1'b1;
      r <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge ref_clk);
         if (awRdy) aw <= 1'b0;
         if (wRdy) w <= 1'b0;
         if (arRdy) ar <= 1'b0;
         if (rd ? rVld : bVld) break;
      end
      b <= 1'b0;
      r <= 1'b0;
      limit(n);
   endtask
   task automatic cmd(input logic [2:0] op, input logic [11:0] a);
      int n;
      axi(1'b0, REG_CMD, {4'h0, a, 10'h0, bk, 1'h0, op});
      for (n = 0; n < 60 && {bus.rasN, bus.casN, bus.weN} !== op; n++) @(negedge ref_clk);
      limit(n);
      seen = cyc;
      if (op == CMD_READ) q = {};
   endtask
   function automatic logic [17:0] ev(input int j);
      logic [8:0] n;
      n = (c & ~m) | ((c + 9'(j)) & m);
      ev = {~lm, {bk, rw[4:0], n} & {{8{~lm[1]}}, {8{~lm[0]}}}};
   endfunction
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   // Lanes that are off float, so their bits are zeroed before comparing
   always @(negedge ref_clk) if (bus.dqOe != 2'h0)
      q.push_back({bus.dqOe, bus.dqOut & {{8{bus.dqOe[1]}}, {8{bus.dqOe[0]}}}});
   initial begin
      void'($urandom(32'h5023));
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      axi(1'b1, 8'h10, 32'h0);
      `CHK(rresp, RESP_SLVERR)
      for (t = 0; t < 7; t++) begin
         {bk, rw, c} = 23'($urandom());
         lm = t < 4 ? 2'($urandom_range(2)) : 2'h0;
         if (t > 3) c = 9'h1FD;
         m = t < 4 ? (9'h1 << t) - 9'h1 : 9'h1FF;
         @(posedge ref_clk) code <= t < 4 ? 3'(t) : 3'h7;
         axi(1'b0, REG_MASK, {30'h0, lm});
         `CHK(bresp, RESP_OKAY)
         axi(1'b1, REG_MASK, 32'h0);
         `CHK(rdata, {30'h0, lm})
         cmd(CMD_ACTIVE, rw);
         cmd(CMD_READ, {3'h2, c});
         k = seen;
         if (t == 4) cmd(CMD_TERMINATE, 12'h0);
         if (t == 5) cmd(CMD_WRITE, 12'h0);
         if (t == 6) cmd(CMD_PRECHARGE, 12'h0);
         // The flag pulses in the cycle after the device samples the command
         if (t > 3) begin
            @(negedge ref_clk);
            `CHK(inv, t == 5)
         end
         repeat (12) @(negedge ref_clk);
         for (i = 0; i < q.size(); i++) `CHK(q[i], ev(i))
         `CHK(q.size(), t < 4 ? int'(m) + 1 : seen - k - (t == 5 ? 2 : 0))
         `CHK(act[bk], t > 3 && t != 6)
         cmd(CMD_PRECHARGE, 12'h400);
         repeat (2) @(negedge ref_clk);
         `CHK(act, 4'h0)
         $display("test %0d done", t);
      end
      wrap_up();
   end
endmodule
`default_nettype wire

// File: design/sar_bank_timer.sv
// Per-bank spacing counters and open flag for the controller
`timescale 1ns/1ns
`default_nettype none
module sar_bank_timer (
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic activate, // ACTIVE issued to this bank
   input wire logic precharge, // PRECHARGE issued to this bank
   output logic accessOk, // READ or WRITE may go out
   output logic activateOk, // ACTIVE may go out
   output logic rowOpen // A row is open in this bank
);
   import sar_pkg::*;
   logic [TMR_W-1:0] sinceAct_ff, nxt_sinceAct;
   logic [TMR_W-1:0] sincePre_ff, nxt_sincePre;
   logic open_ff, nxt_open;

   always_comb begin
      nxt_sinceAct = activate ? '0 : bump(sinceAct_ff);
      nxt_sincePre = precharge ? '0 : bump(sincePre_ff);
      nxt_open = activate | (open_ff & ~precharge);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sinceAct_ff <= TMR_MAX;
         sincePre_ff <= TMR_MAX;
         open_ff <= 1'b0;
      end else begin
         sinceAct_ff <= nxt_sinceAct;
         sincePre_ff <= nxt_sincePre;
         open_ff <= nxt_open;
      end
   end

   assign accessOk = sinceAct_ff >= RCD_LIM;
   // Saturation keeps an old bank's spacing limits permanently met; an open row still blocks ACTIVE
   assign activateOk = !open_ff && sinceAct_ff >= RC_LIM && sincePre_ff >= RP_LIM;
   assign rowOpen = open_ff;
endmodule
`default_nettype wire

// File: design/sar_ctrl.sv
// Controller end: AXI4-Lite registers, command issue with per-bank spacing, read capture
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sar_ctrl (
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   sar_if.ctl mem, // Pins to the SDRAM
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [7:0] awaddr, // Write byte address
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   output logic [1:0] bresp, // Write response
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   input wire logic [7:0] araddr, // Read byte address
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp // Read response
);
   import sar_pkg::*;

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
   logic [7:0] awA_ff, nxt_awA;
   logic [31:0] wD_ff, nxt_wD;
   logic [3:0] wS_ff, nxt_wS;
   logic awready_ff, nxt_awready, wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic cmdWr, maskWr;
   logic pend_ff, nxt_pend, seen_ff, nxt_seen;
   logic [LANES-1:0] mask_ff, nxt_mask;
   logic [DQ_W-1:0] cap_ff, nxt_cap;
   sar_cmd_t pOp_ff, nxt_pOp, op_ff, nxt_op;
   logic [BANK_W-1:0] pBank_ff, nxt_pBank;
   logic [ROW_W-1:0] pAddr_ff, nxt_pAddr;
   logic [BANKS-1:0] accOk, actOk, rowOpen, actPulse, prePulse;

   always_comb begin
      nxt_awHeld = awHeld_ff | (awvalid & awready_ff);
      nxt_awA = (awvalid & awready_ff) ? awaddr : awA_ff;
      nxt_wHeld = wHeld_ff | (wvalid & wready_ff);
      nxt_wD = (wvalid & wready_ff) ? wdata : wD_ff;
      nxt_wS = (wvalid & wready_ff) ? wstrb : wS_ff;
      nxt_bvalid = bvalid_ff & ~bready;
      nxt_bresp = bresp_ff;
      cmdWr = 1'b0;
      maskWr = 1'b0;
      if (awHeld_ff && wHeld_ff && !bvalid_ff) begin
         nxt_awHeld = 1'b0;
         nxt_wHeld = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OKAY;
         // A command written while one is pending is refused
         if (awA_ff == REG_CMD && !pend_ff) begin
            cmdWr = |wS_ff;
         end else if (awA_ff == REG_MASK) begin
            maskWr = wS_ff[0];
         end else begin
            nxt_bresp = RESP_SLVERR;
         end
      end
      nxt_awready = !nxt_awHeld && !nxt_bvalid;
      nxt_wready = !nxt_wHeld && !nxt_bvalid;
      nxt_rvalid = rvalid_ff & ~rready;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         case (araddr)
            REG_CMD: nxt_rdata = {4'h0, pAddr_ff, 8'h00, 2'h0, pBank_ff, 1'b0, pOp_ff};
            REG_STATUS: nxt_rdata = {20'h0, rowOpen, 6'h0, seen_ff, pend_ff};
            REG_RDATA: nxt_rdata = {16'h0, cap_ff};
            REG_MASK: nxt_rdata = {30'h0, mask_ff};
            default: begin
               nxt_rdata = '0;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_arready = !nxt_rvalid;
   end

   // ----------------------------------------
   // Command issue and spacing
   // ----------------------------------------
   logic goOk, issue;
   logic [TMR_W-1:0] rrd_ff, nxt_rrd;

   always_comb begin
      goOk = 1'b1;
      if (pOp_ff == CMD_ACTIVE) begin
         goOk = actOk[pBank_ff] && rrd_ff >= RRD_LIM;
      end else if (pOp_ff == CMD_READ || pOp_ff == CMD_WRITE) begin
         // This end never drives dq, so a WRITE cannot contend with read data
         goOk = accOk[pBank_ff];
      end
      issue = pend_ff && goOk;
      for (int b = 0; b < BANKS; b++) begin
         actPulse[b] = issue && pOp_ff == CMD_ACTIVE && pBank_ff == b;
         prePulse[b] = issue && pOp_ff == CMD_PRECHARGE && (pAddr_ff[AP_BIT] || pBank_ff == b);
      end
      nxt_rrd = (issue && pOp_ff == CMD_ACTIVE) ? '0 : bump(rrd_ff);
      nxt_op = issue ? pOp_ff : CMD_NOP;
      nxt_pend = pend_ff && !issue;
      nxt_pOp = pOp_ff;
      nxt_pBank = pBank_ff;
      nxt_pAddr = pAddr_ff;
      if (cmdWr) begin
         nxt_pend = 1'b1;
         nxt_pOp = sar_cmd_t'(wD_ff[CMD_OP_LSB +: 3]);
         nxt_pBank = wD_ff[CMD_BANK_LSB +: BANK_W];
         nxt_pAddr = wD_ff[CMD_ADDR_LSB +: ROW_W];
      end
      // Software sequences the mask around WRITEs
      nxt_mask = maskWr ? wD_ff[LANES-1:0] : mask_ff;
      nxt_cap = cap_ff;
      for (int l = 0; l < LANES; l++) begin
         if (mem.dqOe[l]) begin
            nxt_cap[l*8 +: 8] = mem.dqOut[l*8 +: 8];
         end
      end
      nxt_seen = (seen_ff && !cmdWr) || |mem.dqOe;
   end

   for (genvar g = 0; g < BANKS; g++) begin : gBank
      sar_bank_timer uTmr (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .activate(actPulse[g]),
         .precharge(prePulse[g]),
         .accessOk(accOk[g]),
         .activateOk(actOk[g]),
         .rowOpen(rowOpen[g])
      );
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awA_ff <= '0;
         wD_ff <= '0;
         wS_ff <= '0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= '0;
         pend_ff <= 1'b0;
         seen_ff <= 1'b0;
         mask_ff <= MASK_RESET;
         cap_ff <= '0;
         pOp_ff <= CMD_NOP;
         op_ff <= CMD_NOP;
         pBank_ff <= '0;
         pAddr_ff <= '0;
         rrd_ff <= TMR_MAX;
      end else begin
         awHeld_ff <= nxt_awHeld;
         wHeld_ff <= nxt_wHeld;
         awA_ff <= nxt_awA;
         wD_ff <= nxt_wD;
         wS_ff <= nxt_wS;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         pend_ff <= nxt_pend;
         seen_ff <= nxt_seen;
         mask_ff <= nxt_mask;
         cap_ff <= nxt_cap;
         pOp_ff <= nxt_pOp;
         op_ff <= nxt_op;
         pBank_ff <= nxt_pBank;
         pAddr_ff <= nxt_pAddr;
         rrd_ff <= nxt_rrd;
      end
   end

   assign mem.csN = 1'b0;
   assign {mem.rasN, mem.casN, mem.weN} = op_ff;
   assign mem.bankSel = pBank_ff;
   assign mem.addr = pAddr_ff;
   assign mem.byteMask = mask_ff;
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
endmodule
`default_nettype wire

// File: design/sar_device.sv
// SDRAM end: bank state, read-burst engine, latency pipe and masked output
`timescale 1ns/1ns
`default_nettype none
module sar_device (
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   sar_if.dev bus, // Pins from the controller
   input wire logic [2:0] burstCode, // Burst length code, 7 is full page
   output logic [sar_pkg::BANKS-1:0] bankActive, // Banks holding an open row
   output logic invalidWrite // WRITE cut a read while mask was low
);
   import sar_pkg::*;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic [2:0] cmdCode;
   logic isAct;
   logic isRead;
   logic isWrite;
   logic isPre;
   logic isTerm;
   logic [BANK_W-1:0] ba;
   logic apSel;

   assign cmdCode = {bus.rasN, bus.casN, bus.weN};
   assign isAct = !bus.csN && cmdCode == CMD_ACTIVE;
   assign isRead = !bus.csN && cmdCode == CMD_READ;
   assign isWrite = !bus.csN && cmdCode == CMD_WRITE;
   assign isPre = !bus.csN && cmdCode == CMD_PRECHARGE;
   assign isTerm = !bus.csN && cmdCode == CMD_TERMINATE;
   assign ba = bus.bankSel;
   assign apSel = bus.addr[AP_BIT];

   // ----------------------------------------
   // Burst engine state
   // ----------------------------------------
   logic engValid_ff, nxt_engValid;
   logic [BANK_W-1:0] engBank_ff, nxt_engBank;
   logic [ROW_W-1:0] engRow_ff, nxt_engRow;
   logic [COL_W-1:0] engCol_ff, nxt_engCol;
   logic [COL_W-1:0] engMask_ff, nxt_engMask;
   logic [COL_W-1:0] engLeft_ff, nxt_engLeft;
   logic engFull_ff, nxt_engFull;
   logic engAp_ff, nxt_engAp;
   logic engLast;
   logic apClose;

   assign engLast = !engFull_ff && engLeft_ff == '0;
   // The last beat has been fetched, so the row may close now
   assign apClose = engValid_ff && engLast && engAp_ff;

   // ----------------------------------------
   // Bank state
   // ----------------------------------------
   logic [BANKS-1:0] bankOpen_ff, nxt_bankOpen;
   logic [ROW_W-1:0] bankRow_ff [BANKS];
   logic [ROW_W-1:0] nxt_bankRow [BANKS];

   always_comb begin
      nxt_bankOpen = bankOpen_ff;
      for (int b = 0; b < BANKS; b++) begin
         nxt_bankRow[b] = bankRow_ff[b];
      end
      if (apClose) begin
         nxt_bankOpen[engBank_ff] = 1'b0;
      end
      if (isAct) begin
         nxt_bankOpen[ba] = 1'b1;
         nxt_bankRow[ba] = bus.addr;
      end
      if (isPre) begin
         if (apSel) begin
            nxt_bankOpen = '0;
         end else begin
            nxt_bankOpen[ba] = 1'b0;
         end
      end
      // Terminate touches no bank, so its row stays open
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bankOpen_ff <= '0;
         for (int b = 0; b < BANKS; b++) begin
            bankRow_ff[b] <= '0;
         end
      end else begin
         bankOpen_ff <= nxt_bankOpen;
         for (int b = 0; b < BANKS; b++) begin
            bankRow_ff[b] <= nxt_bankRow[b];
         end
      end
   end

   // ----------------------------------------
   // Burst engine
   // ----------------------------------------
   always_comb begin
      nxt_engValid = engValid_ff;
      nxt_engBank = engBank_ff;
      nxt_engRow = engRow_ff;
      nxt_engCol = engCol_ff;
      nxt_engMask = engMask_ff;
      nxt_engLeft = engLeft_ff;
      nxt_engFull = engFull_ff;
      nxt_engAp = engAp_ff;
      if (engValid_ff) begin
         if (engLast) begin
            nxt_engValid = 1'b0;
         end else begin
            nxt_engCol = nextCol(engCol_ff, engMask_ff);
            nxt_engLeft = engLeft_ff - 9'h001;
         end
      end
      // A new READ simply replaces the running burst, any cycle, any bank with an open row
      if (isRead && bankOpen_ff[ba]) begin
         nxt_engValid = 1'b1;
         nxt_engBank = ba;
         nxt_engRow = bankRow_ff[ba];
         nxt_engCol = bus.addr[COL_W-1:0];
         nxt_engMask = burstMask(burstCode);
         nxt_engLeft = burstMask(burstCode);
         nxt_engFull = burstCode == BL_FULL;
         nxt_engAp = apSel && burstCode != BL_FULL;
      end
      if (isTerm || isWrite) begin
         nxt_engValid = 1'b0;
      end
      if (isPre && (apSel || ba == engBank_ff)) begin
         nxt_engValid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         engValid_ff <= 1'b0;
         engBank_ff <= '0;
         engRow_ff <= '0;
         engCol_ff <= '0;
         engMask_ff <= '0;
         engLeft_ff <= '0;
         engFull_ff <= 1'b0;
         engAp_ff <= 1'b0;
      end else begin
         engValid_ff <= nxt_engValid;
         engBank_ff <= nxt_engBank;
         engRow_ff <= nxt_engRow;
         engCol_ff <= nxt_engCol;
         engMask_ff <= nxt_engMask;
         engLeft_ff <= nxt_engLeft;
         engFull_ff <= nxt_engFull;
         engAp_ff <= nxt_engAp;
      end
   end

   // ----------------------------------------
   // Latency pipe and output stage
   // ----------------------------------------
   // Engine, pipe and output register together give read_latency edges
   logic [PIPE_D-1:0] pipeValid_ff, nxt_pipeValid;
   logic [DQ_W-1:0] pipeData_ff [PIPE_D];
   logic [DQ_W-1:0] nxt_pipeData [PIPE_D];
   logic [LANES-1:0] dqmQ_ff, nxt_dqmQ;
   logic [LANES-1:0] outOe_ff, nxt_outOe;
   logic [DQ_W-1:0] outData_ff, nxt_outData;
   logic invWr_ff, nxt_invWr;
   logic readBusy;

   assign readBusy = engValid_ff || |pipeValid_ff;

   always_comb begin
      nxt_pipeValid[0] = engValid_ff;
      nxt_pipeData[0] = readPattern(engBank_ff, engRow_ff, engCol_ff);
      for (int s = 1; s < PIPE_D; s++) begin
         nxt_pipeValid[s] = pipeValid_ff[s-1];
         nxt_pipeData[s] = pipeData_ff[s-1];
      end
      if (isWrite) begin
         nxt_pipeValid = '0;
      end
      nxt_dqmQ = bus.byteMask;
      nxt_outData = pipeData_ff[PIPE_D-1];
      for (int l = 0; l < LANES; l++) begin
         // Mask sampled one edge earlier gates this lane: two clocks in all
         nxt_outOe[l] = pipeValid_ff[PIPE_D-1] && !dqmQ_ff[l];
      end
      if (isWrite) begin
         nxt_outOe = '0;
      end
      nxt_invWr = isWrite && readBusy && dqmQ_ff != {LANES{1'b1}};
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pipeValid_ff <= '0;
         for (int s = 0; s < PIPE_D; s++) begin
            pipeData_ff[s] <= '0;
         end
         dqmQ_ff <= {LANES{1'b1}};
         outOe_ff <= '0;
         outData_ff <= '0;
         invWr_ff <= 1'b0;
      end else begin
         pipeValid_ff <= nxt_pipeValid;
         for (int s = 0; s < PIPE_D; s++) begin
            pipeData_ff[s] <= nxt_pipeData[s];
         end
         dqmQ_ff <= nxt_dqmQ;
         outOe_ff <= nxt_outOe;
         outData_ff <= nxt_outData;
         invWr_ff <= nxt_invWr;
      end
   end

   assign bus.dqOut = outData_ff;
   assign bus.dqOe = outOe_ff;
   assign bankActive = bankOpen_ff;
   assign invalidWrite = invWr_ff;
endmodule
`default_nettype wire

// File: design/sar_if.sv
// Command, address, mask and data pins between controller and SDRAM
`timescale 1ns/1ns
`default_nettype none
interface sar_if;
   logic csN;
   logic rasN;
   logic casN;
   logic weN;
   logic [sar_pkg::BANK_W-1:0] bankSel;
   logic [sar_pkg::ROW_W-1:0] addr;
   logic [sar_pkg::LANES-1:0] byteMask;
   logic [sar_pkg::DQ_W-1:0] dqOut;
   logic [sar_pkg::LANES-1:0] dqOe;
   modport dev (
      input csN, rasN, casN, weN, bankSel, addr, byteMask,
      output dqOut, dqOe
   );
   modport ctl (
      output csN, rasN, casN, weN, bankSel, addr, byteMask,
      input dqOut, dqOe
   );
endinterface
`default_nettype wire

// File: design/sar_pkg.sv
// Shared constants, types and helpers for both ends of the SDRAM read-burst link
// Notes on behaviour
// - Controller opens a row with ACTIVE before access
// - READ or WRITE waits activate_to_access_delay after ACTIVE
// - Same-bank ACTIVE needs precharge and row_cycle_time
// - Different-bank ACTIVEs spaced by bank_to_bank_activate_delay
// - First word read_latency after READ, then every clock
// - Finished burst leaves data lines high impedance
// - Full-page burst wraps to column 0 until stopped
// - New READ truncates or chains bursts seamlessly
// - READ accepted on any clock after a READ
// - WRITE follows last read word, maybe one idle
// - Mask high two clocks before truncating WRITE
// - Truncating WRITE forces data lines high impedance
// - Mask low at WRITE so data is written
// - Same-bank PRECHARGE ends read burst at read_latency-1
// - Wait precharge_time after PRECHARGE for that bank
// - BURST TERMINATE truncates reads at read_latency-1
// - BURST TERMINATE leaves the row open
// - Auto precharge closes row when burst completes
// - auto_precharge_select chooses auto precharge per command
// - Full-page bursts ignore auto precharge
// - Read lane driven two clocks after mask low
package sar_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int READ_LATENCY = 3;
   localparam int T_RCD_NS = 20;
   localparam int T_RC_NS = 60;
   localparam int T_RRD_NS = 15;
   localparam int T_RP_NS = 20;
   localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RRD_CYC = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] TMR_MAX = 8'hFF;
   // A command decided at edge j is seen one edge later, hence the minus one
   localparam logic [TMR_W-1:0] RCD_LIM = TMR_W'(RCD_CYC - 1);
   localparam logic [TMR_W-1:0] RC_LIM = TMR_W'(RC_CYC - 1);
   localparam logic [TMR_W-1:0] RRD_LIM = TMR_W'(RRD_CYC - 1);
   localparam logic [TMR_W-1:0] RP_LIM = TMR_W'(RP_CYC - 1);
   // ----------------------------------------
   // Array shape and pins
   // ----------------------------------------
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int LANES = 2;
   localparam int AP_BIT = 10;
   localparam int PIPE_D = READ_LATENCY - 2;
   localparam logic [2:0] BL_FULL = 3'h7;
   // Pin code is {rasN, casN, weN} with csN low
   typedef enum logic [2:0] {
      CMD_PRECHARGE = 3'h2,
      CMD_ACTIVE = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_READ = 3'h5,
      CMD_TERMINATE = 3'h6,
      CMD_NOP = 3'h7
   } sar_cmd_t;
   // ----------------------------------------
   // Controller register map
   // ----------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RDATA = 8'h08;
   localparam logic [7:0] REG_MASK = 8'h0C;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_ADDR_LSB = 16;
   localparam logic [LANES-1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [TMR_W-1:0] bump(input logic [TMR_W-1:0] v);
      bump = (v == TMR_MAX) ? v : v + 8'h01;
   endfunction

   // Column bits that advance within a burst; codes 4 to 6 share the full-page mask but end after 512 beats
   function automatic logic [COL_W-1:0] burstMask(input logic [2:0] code);
      case (code)
         3'h0: burstMask = 9'h000;
         3'h1: burstMask = 9'h001;
         3'h2: burstMask = 9'h003;
         3'h3: burstMask = 9'h007;
         default: burstMask = 9'h1FF;
      endcase
   endfunction

   function automatic logic [COL_W-1:0] nextCol(input logic [COL_W-1:0] col,
                                               input logic [COL_W-1:0] mask);
      nextCol = (col & ~mask) | ((col + 9'h001) & mask);
   endfunction

   // Each word names its own bank, low row bits and column
   function automatic logic [DQ_W-1:0] readPattern(input logic [BANK_W-1:0] bank,
                                                   input logic [ROW_W-1:0] row,
                                                   input logic [COL_W-1:0] col);
      readPattern = {bank, row[4:0], col};
   endfunction
endpackage
